/* bench/bus_host.sv */
// serial host model that reaches the charger registers
`timescale 1ns/100ps
`default_nettype none
module bus_host (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_out
);
  localparam logic [6:0] ADR = charger_irq_pkg::SLAVE_ADDR;
  int hp = 10; // half period in mclk cycles; the slave needs at least 8
  initial begin
    scl = 1'h1;
    sda_out = 1'h1;
  end
  // every line change lands just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // start or repeated start, leaving the clock low
  task automatic start();
    sda_out = 1'h1;
    tick(hp);
    scl = 1'h1;
    tick(hp);
    sda_out = 1'h0;
    tick(hp);
    scl = 1'h0;
    tick(2);
  endtask
  task automatic stop();
    sda_out = 1'h0;
    tick(hp);
    scl = 1'h1;
    tick(hp);
    sda_out = 1'h1;
    tick(hp);
  endtask
  // eight bits msb first plus the acknowledge slot; data moves only with the clock low
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int b = 8; b >= 0; b--) begin
      sda_out = o[b];
      tick(hp);
      scl = 1'h1;
      tick(hp);
      i[b] = sda;
      scl = 1'h0;
      tick(2);
    end
  endtask
  // ok is high when all three bytes were acknowledged
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [8:0] r0, r1, r2;
    start();
    xfer({ADR, 1'h0, 1'h1}, r0);
    xfer({a, 1'h1}, r1);
    xfer({d, 1'h1}, r2);
    stop();
    ok = !(r0[0] | r1[0] | r2[0]);
  endtask
  // pointer write, repeated start, one byte closed by a nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r0, r1;
    start();
    xfer({ADR, 1'h0, 1'h1}, r0);
    xfer({a, 1'h1}, r1);
    start();
    xfer({ADR, 1'h1, 1'h1}, r0);
    xfer(9'h1FF, r1);
    stop();
    d = r1[8:1];
  endtask
  // two bytes in one read, the first acknowledged so the slave sends the byte at the next offset too
  task automatic rd2(input logic [7:0] a, output logic [15:0] d);
    logic [8:0] r0, r1, r2;
    start();
    xfer({ADR, 1'h0, 1'h1}, r0);
    xfer({a, 1'h1}, r1);
    start();
    xfer({ADR, 1'h1, 1'h1}, r0);
    xfer(9'h1FE, r1);
    xfer(9'h1FF, r2);
    stop();
    d = {r1[8:1], r2[8:1]};
  endtask
  // address byte alone; ok is high when some slave acknowledged it
  task automatic probe(input logic [6:0] x, output logic ok);
    logic [8:0] r0;
    start();
    xfer({x, 1'h0, 1'h1}, r0);
    stop();
    ok = !r0[0];
  endtask
endmodule
`default_nettype wire

/* bench/charger_irq_chk.sv */
// port assertions for the charger interrupt, status and setup block
`timescale 1ns/100ps
`default_nettype none
module charger_irq_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic [3:0] subblock_ok,
  input wire logic [3:0][7:0] subblock_detail,
  input wire logic irq_n,
  input wire logic charger_pending,
  input wire logic static_write_lock,
  input wire logic [10:0][7:0] setup_bytes
);
  logic [3:0] ok_q;
  logic [3:0][7:0] det_q;
  logic [2:0] hist_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // history of input changes, so a pending rise can be traced to a cause
  always_ff @(posedge mclk) begin
    ok_q <= subblock_ok;
    det_q <= subblock_detail;
    hist_q <= {hist_q[1:0], (ok_q != subblock_ok) || (det_q != subblock_detail)};
  end
  // clock idle high for a while: no read can be clearing flags
  sequence quiet_pend;
    (charger_pending && scl_in)[*8];
  endsequence
  reset_vals_a: assert property ($fell(srst) |-> irq_n && !charger_pending && sda_oe_n
    && !static_write_lock && setup_bytes == '0) else $error("outputs not at reset values");
  event_flag_a: assert property (hist_q[0] && !$past(srst) && !$past(srst, 2)
    |-> ##[1:2] charger_pending) else $error("subblock change not flagged");
  irq_gate_a: assert property (!irq_n |-> charger_pending)
    else $error("interrupt pin low with no flag set");
  pending_hold_a: assert property (quiet_pend |=> charger_pending)
    else $error("flags cleared without a read");
  pending_src_a: assert property ($rose(charger_pending) |-> |hist_q)
    else $error("pending rose with no subblock change");
  lock_blocks_a: assert property ($past(static_write_lock) && !$past(srst) |->
    $stable(setup_bytes[5:1]) && $stable(setup_bytes[7])) else $error("locked setup changed");
  setup_time_a: assert property ($changed({static_write_lock, setup_bytes}) |-> !scl_in)
    else $error("setup changed while clock high");
  sda_time_a: assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
    else $error("data drive changed near clock high");
endmodule
bind charger_irq_status_protect charger_irq_chk i_chk (.mclk, .srst, .scl_in, .sda_oe_n,
  .subblock_ok, .subblock_detail, .irq_n, .charger_pending, .static_write_lock, .setup_bytes);
`default_nettype wire

/* bench/charger_irq_status_protect_tb.sv */
// self-checking bench for the charger interrupt, status and setup block
`timescale 1ns/100ps
`default_nettype none
module charger_irq_status_protect_tb;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic scl, sda_host, sda_oe_n, irq_n, charger_pending, static_write_lock, ok;
  logic [3:0] subblock_ok = 4'h5;
  logic [3:0][7:0] subblock_detail = 32'hD3C2B1A0;
  logic [10:0][7:0] setup_bytes;
  logic [7:0] rv;
  logic [15:0] rv2;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  wire sda = sda_host & sda_oe_n; // open drain with pull-up
  // address, written byte, expected read back; boot setup written once
  row_t rows[12] = '{'{8'hB1, 8'h5A, 8'h5A}, '{8'hB7, 8'h11, 8'h11}, '{8'hB8, 8'h22, 8'h22},
    '{8'hBC, 8'h66, 8'h66}, '{8'hBE, 8'h77, 8'h77}, '{8'hC1, 8'h88, 8'h88},
    '{8'hC3, 8'hAA, 8'hAA}, '{8'hB2, 8'hFF, 8'h05}, '{8'hB3, 8'hFF, 8'hA0},
    '{8'hB6, 8'hFF, 8'hD3}, '{8'hC0, 8'h5A, 8'h00}, '{8'hB0, 8'hFF, 8'h00}};
  charger_irq_status_protect i_charger_irq_status_protect (.mclk, .srst, .scl_in(scl),
    .sda_in(sda), .sda_oe_n, .subblock_ok, .subblock_detail, .irq_n, .charger_pending,
    .static_write_lock, .setup_bytes);
  bus_host i_bus_host (.mclk, .sda, .scl, .sda_out(sda_host));
  always #20 mclk = ~mclk;
  // hang guard, some 30000 cycles above the length of the run
  always @(posedge mclk) begin
    if (++cycles == 80000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    srst = 1'h0;
    i_bus_host.tick(3);
    chk({5'h0, irq_n, charger_pending, static_write_lock}, 8'h04);
    chk(setup_bytes[1], 8'h00);
    foreach (rows[n]) begin
      i_bus_host.wr(rows[n].a, rows[n].w, ok);
      chk({7'h0, ok}, 8'h01);
      i_bus_host.rd(rows[n].a, rv);
      chk(rv, rows[n].e);
    end
    chk(setup_bytes[5], 8'h66);
    // two-byte read: the host acknowledge brings a second byte, from the next slot
    i_bus_host.rd2(8'hB7, rv2);
    chk(rv2[15:8], 8'h11);
    chk(rv2[7:0], 8'h22);
    // a foreign address is left unanswered
    i_bus_host.probe(charger_irq_pkg::SLAVE_ADDR ^ 7'h01, ok);
    chk({7'h0, ok}, 8'h00);
    i_bus_host.wr(8'hB1, 8'h00, ok);
    // each subblock in turn: raise, read back, cleared by the read
    for (int s = 0; s < 4; s++) begin
      subblock_ok[s] = !subblock_ok[s];
      i_bus_host.tick(12);
      chk({6'h0, irq_n, charger_pending}, 8'h01);
      i_bus_host.rd(8'hB0, rv);
      chk(rv, 8'h01 << s);
      i_bus_host.rd(8'hB2, rv);
      chk(rv, {4'h0, subblock_ok});
      chk({7'h0, charger_pending}, 8'h00);
      i_bus_host.rd(8'hB0, rv);
      chk(rv, 8'h00);
    end
    // masked source still flags, but the pin stays quiet
    i_bus_host.wr(8'hB1, 8'h0F, ok);
    subblock_detail[1] = 8'h3C;
    i_bus_host.tick(12);
    chk({6'h0, irq_n, charger_pending}, 8'h03);
    i_bus_host.rd(8'hB0, rv);
    chk(rv, 8'h02);
    // slow host; locked static write is acknowledged but dropped
    i_bus_host.hp = 20;
    i_bus_host.wr(8'hBD, 8'h01, ok);
    chk({7'h0, static_write_lock}, 8'h01);
    i_bus_host.wr(8'hB8, 8'h5A, ok);
    chk({7'h0, ok}, 8'h01);
    i_bus_host.rd(8'hB8, rv);
    chk(rv, 8'h22);
    i_bus_host.wr(8'hB7, 8'h5A, ok);
    chk(setup_bytes[0], 8'h5A);
    i_bus_host.wr(8'hBD, 8'h00, ok);
    i_bus_host.wr(8'hB8, 8'h5A, ok);
    chk(setup_bytes[1], 8'h5A);
    // mid-run reset clears setup and lock; then every static slot refuses writes
    srst = 1'h1;
    i_bus_host.tick(4);
    srst = 1'h0;
    i_bus_host.tick(3);
    chk({5'h0, irq_n, charger_pending, static_write_lock}, 8'h04);
    chk(setup_bytes[1], 8'h00);
    i_bus_host.wr(8'hBD, 8'h01, ok);
    for (int r = 1; r < 8; r++) begin
      if (r != 6) begin
        i_bus_host.wr(8'(8'hB7 + r), 8'hC3, ok);
        chk({7'h0, ok}, 8'h01);
        chk(setup_bytes[r], 8'h00);
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire

/* verilog/charger_irq_pkg.sv */
// constants for the charger interrupt, status and write-protection block
package charger_irq_pkg;

  // serial slave address, seven bits; the eighth bit on the wire is read/write
  localparam logic [6:0] SLAVE_ADDR = 7'h69;

  // register offsets
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'hB0;
  localparam logic [7:0] ADDR_EVENT_MASKS = 8'hB1;
  localparam logic [7:0] ADDR_HEALTH_FLAGS = 8'hB2;
  localparam logic [7:0] ADDR_DETAIL_ZERO = 8'hB3;
  localparam logic [7:0] ADDR_DETAIL_ONE = 8'hB4;
  localparam logic [7:0] ADDR_DETAIL_TWO = 8'hB5;
  localparam logic [7:0] ADDR_DETAIL_THREE = 8'hB6;
  localparam logic [7:0] ADDR_SETUP_ZERO = 8'hB7;
  localparam logic [7:0] ADDR_SETUP_ONE = 8'hB8;
  localparam logic [7:0] ADDR_SETUP_TWO = 8'hB9;
  localparam logic [7:0] ADDR_SETUP_THREE = 8'hBA;
  localparam logic [7:0] ADDR_SETUP_FOUR = 8'hBB;
  localparam logic [7:0] ADDR_SETUP_FIVE = 8'hBC;
  localparam logic [7:0] ADDR_SETUP_SIX = 8'hBD;
  localparam logic [7:0] ADDR_SETUP_SEVEN = 8'hBE;
  localparam logic [7:0] ADDR_SETUP_TEN = 8'hC1;
  localparam logic [7:0] ADDR_SETUP_ELEVEN = 8'hC2;
  localparam logic [7:0] ADDR_SETUP_TWELVE = 8'hC3;

  // setup register storage slots
  localparam int SETUP_SLOTS = 11;
  localparam logic [3:0] SLOT_SETUP_SIX = 4'h6;

  // subblock bit positions, shared by flags, masks and health
  localparam int SUBBLOCKS = 4;
  localparam int BIT_INPUT = 0;
  localparam int BIT_STATE_MACHINE = 1;
  localparam int BIT_BATTERY = 2;
  localparam int BIT_BYPASS = 3;

  // lock bit inside charger_setup_six; one blocks the static setup writes
  localparam int LOCK_BIT = 0;

  // values after reset, and the value read from unmapped offsets
  localparam logic [7:0] RESET_SETUP = 8'h00;
  localparam logic [7:0] RESET_MASKS = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_STAGES = 2;

endpackage

/* verilog/charger_irq_status_protect.sv */
// charger event flags, masks, health, details and protected setup behind a serial slave
`timescale 1ns/100ps
`default_nettype none
module charger_irq_status_protect (
  input wire logic mclk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  input wire logic [3:0] subblock_ok,
  input wire logic [3:0][7:0] subblock_detail,
  output logic irq_n,
  output logic charger_pending,
  output logic static_write_lock,
  output logic [10:0][7:0] setup_bytes
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_PTR = 4'h2,
    ST_PTR_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RDATA_ACK = 4'hC
  } bus_state_t;

  typedef struct packed {
    logic scl_prev;
    logic sda_prev;
    bus_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic drive;
    logic oe_n;
    logic [3:0] flags;
    logic [7:0] masks;
    logic [3:0] ok_prev;
    logic [3:0][7:0] detail_prev;
    logic armed;
    logic [10:0][7:0] setup;
    logic irq_n;
    logic pending;
  } core_t;

  core_t q;
  core_t d;
  logic scl_s;
  logic sda_s;
  logic [1:0] pins_s;

  pin_sync #(
    .WIDTH(2),
    .IDLE(2'h3)
  ) u_pin_sync (
    .mclk(mclk),
    .srst(srst),
    .pin_in({scl_in, sda_in}),
    .pin_out(pins_s)
  );

  // synchronised levels; bit one carries the clock line, bit zero the data line
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // maps an offset to a setup storage slot; top bit says the offset is a setup register
  function automatic logic [4:0] setup_slot(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    unique case (a)
      charger_irq_pkg::ADDR_SETUP_ZERO: r = 5'h10;
      charger_irq_pkg::ADDR_SETUP_ONE: r = 5'h11;
      charger_irq_pkg::ADDR_SETUP_TWO: r = 5'h12;
      charger_irq_pkg::ADDR_SETUP_THREE: r = 5'h13;
      charger_irq_pkg::ADDR_SETUP_FOUR: r = 5'h14;
      charger_irq_pkg::ADDR_SETUP_FIVE: r = 5'h15;
      charger_irq_pkg::ADDR_SETUP_SIX: r = 5'h16;
      charger_irq_pkg::ADDR_SETUP_SEVEN: r = 5'h17;
      charger_irq_pkg::ADDR_SETUP_TEN: r = 5'h18;
      charger_irq_pkg::ADDR_SETUP_ELEVEN: r = 5'h19;
      charger_irq_pkg::ADDR_SETUP_TWELVE: r = 5'h1A;
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // static registers that the lock guards
  function automatic logic is_static(input logic [7:0] a);
    logic r;
    r = 1'b0;
    unique case (a)
      charger_irq_pkg::ADDR_SETUP_ONE, charger_irq_pkg::ADDR_SETUP_TWO,
      charger_irq_pkg::ADDR_SETUP_THREE, charger_irq_pkg::ADDR_SETUP_FOUR,
      charger_irq_pkg::ADDR_SETUP_FIVE, charger_irq_pkg::ADDR_SETUP_SEVEN: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // read multiplexer; unmapped offsets read as zero
  function automatic logic [7:0] read_value(input logic [7:0] a, input core_t s,
                                            input logic [3:0] ok,
                                            input logic [3:0][7:0] det);
    logic [7:0] r;
    logic [4:0] slot;
    r = charger_irq_pkg::READ_UNMAPPED;
    slot = setup_slot(a);
    unique case (a)
      charger_irq_pkg::ADDR_EVENT_FLAGS: r = {4'h0, s.flags};
      charger_irq_pkg::ADDR_EVENT_MASKS: r = s.masks;
      charger_irq_pkg::ADDR_HEALTH_FLAGS: r = {4'h0, ok};
      charger_irq_pkg::ADDR_DETAIL_ZERO: r = det[0];
      charger_irq_pkg::ADDR_DETAIL_ONE: r = det[1];
      charger_irq_pkg::ADDR_DETAIL_TWO: r = det[2];
      charger_irq_pkg::ADDR_DETAIL_THREE: r = det[3];
      default: begin
        if (slot[4]) begin
          r = s.setup[slot[3:0]];
        end
      end
    endcase
    return r;
  endfunction

  // next state: serial slave, register file, event capture and interrupt pin
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [3:0] events;
    logic [3:0] clear;
    logic [4:0] slot;
    logic locked;
    logic [7:0] byte_in;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_seen = 1'b0;
    stop_seen = 1'b0;
    events = 4'h0;
    clear = 4'h0;
    slot = 5'h00;
    locked = 1'b0;
    byte_in = 8'h00;
    d = q;
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;
    scl_rise = scl_s & ~q.scl_prev;
    scl_fall = ~scl_s & q.scl_prev;
    start_seen = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
    stop_seen = scl_s & q.scl_prev & ~q.sda_prev & sda_s;
    // the lock bit lives in a register it does not guard, so it can always be cleared
    locked = q.setup[charger_irq_pkg::SLOT_SETUP_SIX][charger_irq_pkg::LOCK_BIT];
    byte_in = q.shreg;

    // a change of health or detail byte is a subblock state change
    d.ok_prev = subblock_ok;
    d.detail_prev = subblock_detail;
    d.armed = 1'b1;
    for (int i = 0; i < charger_irq_pkg::SUBBLOCKS; i++) begin
      events[i] = q.armed & ((subblock_ok[i] ^ q.ok_prev[i]) |
                             (subblock_detail[i] != q.detail_prev[i]));
    end

    // start and stop win over any transfer in progress; there is no clock stretching,
    // so the host must hold each clock phase for at least eight cycles
    if (start_seen) begin
      d.state = ST_ADDR;
      d.bitcnt = 4'h0;
      d.drive = 1'b0;
    end else if (stop_seen) begin
      d.state = ST_IDLE;
      d.drive = 1'b0;
    end else begin
      unique case (q.state)
        // idle until a start; the data line stays released
        ST_IDLE: begin
          d.drive = 1'b0;
        end
        // receive a byte: bits are taken on the clock rise, the byte acts on the fall after bit 8
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            d.shreg = {q.shreg[6:0], sda_s};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == charger_irq_pkg::BITS_PER_BYTE) begin
            d.bitcnt = 4'h0;
            if (q.state == ST_ADDR) begin
              // a foreign address is not acknowledged; wait for the next start
              if (byte_in[7:1] == charger_irq_pkg::SLAVE_ADDR) begin
                d.rw = byte_in[0];
                d.drive = 1'b1;
                d.state = ST_ADDR_ACK;
              end else begin
                d.state = ST_IDLE;
              end
            end else if (q.state == ST_PTR) begin
              // the pointer selects the register for the data bytes that follow
              d.ptr = byte_in;
              d.drive = 1'b1;
              d.state = ST_PTR_ACK;
            end else begin
              slot = setup_slot(q.ptr);
              // a locked static write is dropped but still acknowledged
              if (slot[4] && !(locked && is_static(q.ptr))) begin
                d.setup[slot[3:0]] = byte_in;
              end
              // all eight mask bits are kept for readback; only the low four gate the pin
              if (q.ptr == charger_irq_pkg::ADDR_EVENT_MASKS) begin
                d.masks = byte_in;
              end
              d.ptr = q.ptr + 8'h01;
              d.drive = 1'b1;
              d.state = ST_WDATA_ACK;
            end
          end
        end
        // hold the acknowledge until the host's clock falls again
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            d.drive = 1'b0;
            d.state = ST_WDATA;
          end
        end
        // after an acknowledge: load the next read byte or go on to the pointer
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          if (scl_rise && q.state == ST_RDATA_ACK && sda_s) begin
            d.state = ST_IDLE; // host refused more data
          end else if (scl_fall) begin
            // load the byte; a flag read clears only the bits it returned
            if (q.state == ST_RDATA_ACK || q.rw) begin
              d.shreg = read_value(q.ptr, q, subblock_ok, subblock_detail);
              if (q.ptr == charger_irq_pkg::ADDR_EVENT_FLAGS) begin
                clear = q.flags;
              end
              d.drive = ~d.shreg[7];
              d.ptr = q.ptr + 8'h01;
              d.bitcnt = 4'h0;
              d.state = ST_RDATA;
            end else begin
              // write: the next byte is the register pointer
              d.drive = 1'b0;
              d.state = ST_PTR;
            end
          end
        end
        // shift the read byte out; the eighth fall hands the line to the host
        ST_RDATA: begin
          if (scl_rise) begin
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (q.bitcnt == charger_irq_pkg::BITS_PER_BYTE) begin
              d.drive = 1'b0;
              d.state = ST_RDATA_ACK;
            end else begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.drive = ~q.shreg[6];
            end
          end
        end
        // an illegal state code drops back to idle
        default: begin
          d.state = ST_IDLE;
          d.drive = 1'b0;
        end
      endcase
    end

    // an event landing in the clearing cycle survives the clear
    d.flags = (q.flags & ~clear) | events;
    d.pending = |d.flags;
    d.irq_n = ~|(d.flags & ~d.masks[3:0]);
    // the open-drain enable has its own flop so the pin has no gate after the register
    d.oe_n = ~d.drive;
  end

  // every state bit resets to a constant
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
      // lines idle high, so the edge detectors see no false start after reset
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.state <= ST_IDLE;
      q.masks <= charger_irq_pkg::RESET_MASKS;
      q.setup <= {charger_irq_pkg::SETUP_SLOTS{charger_irq_pkg::RESET_SETUP}};
      q.irq_n <= 1'b1;
      q.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign sda_oe_n = q.oe_n;
  assign irq_n = q.irq_n;
  assign charger_pending = q.pending;
  assign static_write_lock = q.setup[charger_irq_pkg::SLOT_SETUP_SIX][charger_irq_pkg::LOCK_BIT];
  assign setup_bytes = q.setup;

endmodule
`default_nettype wire

/* verilog/pin_sync.sv */
// two flip-flop synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t q;
  sync_t d;

  // the first stage feeds only the second stage
  always_comb begin
    d = q;
    d.meta = pin_in;
    d.stable = q.meta;
  end

  // resets to the idle bus level so no false start is seen
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= {IDLE, IDLE};
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.stable;

endmodule
`default_nettype wire
